// *** common/pcgc_pkg.sv ***
// shared constants and types of the counter group register bank
`default_nettype none
package pcgc_pkg;
    // ****************************
    // addressing
    // ****************************
    localparam int ADDR_W = 17;
    localparam logic [ADDR_W-1:0] SNAP_OFF = 17'h00d88;
    localparam logic [ADDR_W-1:0] SCR_OFF = 17'h00df8;
    localparam logic [ADDR_W-1:0] CFGR_OFF = 17'h00e00;
    localparam logic [ADDR_W-1:0] CR_OFF = 17'h00e04;
    localparam logic [ADDR_W-1:0] PAGE1_BASE = 17'h10000;
    // ****************************
    // field positions
    // ****************************
    localparam int SNAP_TRIG_BIT = 0;
    localparam int SCR_PRESENT_BIT = 31;
    localparam int SCR_PART_NS_BIT = 3;
    localparam int SCR_MSG_NS_BIT = 2;
    localparam int SCR_NS_ALLOW_BIT = 1;
    localparam int SCR_SEC_OBS_BIT = 0;
    localparam int CFG_PART_FILT_BIT = 25;
    localparam int CFG_PART_MON_BIT = 24;
    localparam int CFG_SHARED_FILT_BIT = 23;
    localparam int CFG_CAPTURE_BIT = 22;
    localparam int CFG_MSG_BIT = 21;
    localparam int CFG_RELOC_BIT = 20;
    localparam int CFG_SIZE_LSB = 8;
    localparam int CFG_COUNTER_COUNT_MINUS_ONE_LSB = 0;
    localparam int CR_EN_BIT = 0;
    // ****************************
    // reset values
    // ****************************
    localparam logic RST_PART_NS = 1'b0;
    localparam logic RST_MSG_NS = 1'b1;
    localparam logic RST_NS_ALLOW = 1'b1;
    localparam logic RST_SEC_OBS = 1'b0;
    localparam logic RST_GLOBAL_EN = 1'b0;
    // ****************************
    // carriers
    // ****************************
    typedef struct packed {
        logic valid;
        logic write;
        logic nonsecure;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } pcgc_req_s;
endpackage
`default_nettype wire

// *** rtl/pcgc_regs.sv ***
// control, secure control, configuration and snapshot registers of a counter group
// Functional notes
// - write one to bit zero snapshots all counters
// - snapshot register always reads zero
// - no capture support: shadows, snapshot read zero
// - secure control bit 31 reads one
// - bit 3 sets partition ns on secure messages
// - bit 2 selects message ns attribute, resets one
// - ns access denied reads zero, ignores writes
// - bit 1 allows ns access, forces ns messages
// - bit 0 zero forces secure filter select off
// - no security support: secure control reads zero
// - single-state group accepts all, messages ns
// - secure control register secure access only
// - bit 25 reports partition filter capability
// - bit 24 partition monitoring, needs messages
// - bit 23 reports shared filter select
// - bit 21 reports message interrupt capability
// - bit 20 relocates snapshot to second page
// - bits 13:8 counter width minus one
// - bits 5:0 counter count minus one
// - control bit 0 is global counter enable
`default_nettype none
module pcgc_regs #(
    parameter int NUM_CTR = 4,
    parameter int CTR_WIDTH = 32,
    parameter bit SECURE_IMPL = 1'b1,
    parameter bit MSG_IMPL = 1'b1,
    parameter bit PART_NS_IMPL = 1'b1,
    parameter bit PART_MON_IMPL = 1'b1,
    parameter bit PART_FILT_IMPL = 1'b0,
    parameter bit SHARED_FILT = 1'b0,
    parameter bit CAPTURE_IMPL = 1'b1,
    parameter bit RELOC_IMPL = 1'b0
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire pcgc_pkg::pcgc_req_s I_REQ,
    input wire logic [NUM_CTR-1:0][CTR_WIDTH-1:0] I_EVENT_COUNT,
    output logic O_ACK,
    output logic [31:0] O_RDATA,
    output logic [NUM_CTR-1:0][CTR_WIDTH-1:0] O_SHADOW_VALUE,
    output logic O_GLOBAL_EN,
    output logic O_SECURE_OBSERVE,
    output logic O_MSG_NONSECURE,
    output logic O_MSG_PARTITION_NS
);
    import pcgc_pkg::*;

    // ****************************
    // constant configuration word
    // ****************************
    localparam logic [5:0] SIZE_CODE = 6'(CTR_WIDTH - 1);
    localparam logic [5:0] COUNTER_COUNT_MINUS_ONE_CODE = 6'(NUM_CTR - 1);
    localparam logic PART_MON = PART_MON_IMPL & MSG_IMPL;
    localparam logic [31:0] CFG_WORD = (32'(PART_FILT_IMPL) << CFG_PART_FILT_BIT)
        | (32'(PART_MON) << CFG_PART_MON_BIT)
        | (32'(SHARED_FILT) << CFG_SHARED_FILT_BIT)
        | (32'(CAPTURE_IMPL) << CFG_CAPTURE_BIT)
        | (32'(MSG_IMPL) << CFG_MSG_BIT)
        | (32'(RELOC_IMPL) << CFG_RELOC_BIT)
        | (32'(SIZE_CODE) << CFG_SIZE_LSB)
        | (32'(COUNTER_COUNT_MINUS_ONE_CODE) << CFG_COUNTER_COUNT_MINUS_ONE_LSB);
    localparam logic [ADDR_W-1:0] SNAP_ADDR = RELOC_IMPL ? (PAGE1_BASE | SNAP_OFF) : SNAP_OFF;

    // ****************************
    // state
    // ****************************
    logic part_ns_q, part_ns_d;
    logic msg_ns_q, msg_ns_d;
    logic ns_allow_q, ns_allow_d;
    logic sec_obs_q, sec_obs_d;
    logic gen_q, gen_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic eff_msg_ns_q, eff_msg_ns_d;
    logic eff_part_ns_q, eff_part_ns_d;
    logic snap_fire;
    logic [31:0] scr_word;
    logic access_ok;
    logic sec_req;
    logic scr_wr;
    logic sel_snap, sel_scr, sel_cfgr, sel_cr;

    // ****************************
    // decode and next values
    // ****************************
    always_comb begin
        sel_snap = (I_REQ.addr == SNAP_ADDR);
        sel_scr = (I_REQ.addr == SCR_OFF);
        sel_cfgr = (I_REQ.addr == CFGR_OFF);
        sel_cr = (I_REQ.addr == CR_OFF);
        access_ok = I_REQ.valid & (~I_REQ.nonsecure | ~SECURE_IMPL | ns_allow_q);
        sec_req = access_ok & SECURE_IMPL & ~I_REQ.nonsecure;
        scr_wr = sec_req & I_REQ.write & sel_scr;
        snap_fire = access_ok & I_REQ.write & sel_snap & CAPTURE_IMPL & I_REQ.wdata[SNAP_TRIG_BIT];
    end

    // ****************************
    // secure control group
    // ****************************
    always_comb begin
        part_ns_d = part_ns_q;
        msg_ns_d = msg_ns_q;
        ns_allow_d = ns_allow_q;
        sec_obs_d = sec_obs_q;
        if (scr_wr) begin
            part_ns_d = I_REQ.wdata[SCR_PART_NS_BIT] & PART_NS_IMPL;
            msg_ns_d = I_REQ.wdata[SCR_MSG_NS_BIT] | ~MSG_IMPL;
            ns_allow_d = I_REQ.wdata[SCR_NS_ALLOW_BIT];
            sec_obs_d = I_REQ.wdata[SCR_SEC_OBS_BIT] & SECURE_IMPL;
        end
        eff_msg_ns_d = ~SECURE_IMPL | ns_allow_d | msg_ns_d;
        eff_part_ns_d = SECURE_IMPL & PART_NS_IMPL & part_ns_d & ~(ns_allow_d | msg_ns_d);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            part_ns_q <= RST_PART_NS;
            msg_ns_q <= RST_MSG_NS;
            ns_allow_q <= RST_NS_ALLOW;
            sec_obs_q <= RST_SEC_OBS;
            eff_msg_ns_q <= RST_MSG_NS | RST_NS_ALLOW;
            eff_part_ns_q <= RST_PART_NS;
        end else begin
            part_ns_q <= part_ns_d;
            msg_ns_q <= msg_ns_d;
            ns_allow_q <= ns_allow_d;
            sec_obs_q <= sec_obs_d;
            eff_msg_ns_q <= eff_msg_ns_d;
            eff_part_ns_q <= eff_part_ns_d;
        end
    end

    // ****************************
    // global control group
    // ****************************
    always_comb begin
        gen_d = gen_q;
        if (access_ok & I_REQ.write & sel_cr) begin
            gen_d = I_REQ.wdata[CR_EN_BIT];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            gen_q <= RST_GLOBAL_EN;
        end else begin
            gen_q <= gen_d;
        end
    end

    // ****************************
    // bus answer group
    // ****************************
    always_comb begin
        scr_word = '0;
        if (SECURE_IMPL) begin
            scr_word[SCR_PRESENT_BIT] = 1'b1;
            scr_word[SCR_PART_NS_BIT] = part_ns_q & ~(msg_ns_q | ns_allow_q);
            scr_word[SCR_MSG_NS_BIT] = msg_ns_q & MSG_IMPL;
            scr_word[SCR_NS_ALLOW_BIT] = ns_allow_q;
            scr_word[SCR_SEC_OBS_BIT] = sec_obs_q;
        end
        ack_d = I_REQ.valid;
        rdata_d = '0;
        if (access_ok & ~I_REQ.write) begin
            if (sel_scr & sec_req) begin
                rdata_d = scr_word;
            end else if (sel_cfgr) begin
                rdata_d = CFG_WORD;
            end else if (sel_cr) begin
                rdata_d = 32'(gen_q) << CR_EN_BIT;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************
    // shadow values
    // ****************************
    genvar g;
    generate
        for (g = 0; g < NUM_CTR; g++) begin : g_shadow
            logic [CTR_WIDTH-1:0] shadow_q, shadow_d;
            always_comb begin
                shadow_d = snap_fire ? I_EVENT_COUNT[g] : shadow_q;
            end
            always_ff @(posedge I_CLK) begin
                if (I_RST) begin
                    shadow_q <= '0;
                end else begin
                    shadow_q <= shadow_d;
                end
            end
            assign O_SHADOW_VALUE[g] = shadow_q;
        end
    endgenerate

    assign O_ACK = ack_q;
    assign O_RDATA = rdata_q;
    assign O_GLOBAL_EN = gen_q;
    assign O_SECURE_OBSERVE = sec_obs_q;
    assign O_MSG_NONSECURE = eff_msg_ns_q;
    assign O_MSG_PARTITION_NS = eff_part_ns_q;

    // ****************************
    // checks
    // ****************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    snap_copy_a: assert property (snap_fire |=> O_SHADOW_VALUE == $past(I_EVENT_COUNT))
        else $error("snapshot did not copy counters");
    snap_read_a: assert property (I_REQ.valid & ~I_REQ.write & sel_snap |=> O_ACK && O_RDATA == 32'h0)
        else $error("snapshot register read nonzero");
    no_capture_a: assert property (!CAPTURE_IMPL |-> $stable(O_SHADOW_VALUE))
        else $error("shadow changed without capture support");
    scr_top_a: assert property (sec_req & ~I_REQ.write & sel_scr |=> O_RDATA[SCR_PRESENT_BIT] == 1'b1)
        else $error("security present bit not one");
    ns_deny_a: assert property (SECURE_IMPL && I_REQ.valid && I_REQ.nonsecure && !ns_allow_q
        |=> O_RDATA == 32'h0 && $stable(O_GLOBAL_EN))
        else $error("denied nonsecure access had effect");
    scr_ns_a: assert property (I_REQ.valid & I_REQ.nonsecure & sel_scr |=> O_RDATA == 32'h0 && $stable(ns_allow_q))
        else $error("nonsecure reached secure control");
    msg_attr_a: assert property (ns_allow_q |-> ##1 O_MSG_NONSECURE || $past(sec_req & I_REQ.write & sel_scr))
        else $error("messages not nonsecure while access allowed");
    gen_write_a: assert property (access_ok & I_REQ.write & sel_cr |=> O_GLOBAL_EN == $past(I_REQ.wdata[CR_EN_BIT]))
        else $error("global enable not updated");
    cfg_read_a: assert property (access_ok & ~I_REQ.write & sel_cfgr |=> O_RDATA[13:8] == SIZE_CODE
        && O_RDATA[5:0] == COUNTER_COUNT_MINUS_ONE_CODE)
        else $error("configuration read wrong");
    sec_obs_a: assert property (!sec_obs_q |-> !O_SECURE_OBSERVE)
        else $error("secure observe without enable");

    // ****************************
    // checks: reset, bus answer and snapshot hold
    // ****************************
    rst_values_a: assert property ($past(I_RST) |-> !O_ACK && O_RDATA == 32'h0 && !O_GLOBAL_EN
        && O_MSG_NONSECURE && !O_SECURE_OBSERVE && !O_MSG_PARTITION_NS)
        else $error("outputs not at reset values");
    ack_pulse_a: assert property (I_REQ.valid |=> O_ACK)
        else $error("request not acknowledged");
    ack_idle_a: assert property (!I_REQ.valid |=> !O_ACK)
        else $error("acknowledge without request");
    write_rdata_a: assert property (I_REQ.valid & I_REQ.write |=> O_RDATA == 32'h0)
        else $error("write returned read data");
    snap_hold_a: assert property (!snap_fire |=> $stable(O_SHADOW_VALUE))
        else $error("shadow changed without snapshot");
    snap_bit0_a: assert property (access_ok & I_REQ.write & sel_snap & !I_REQ.wdata[SNAP_TRIG_BIT]
        |=> $stable(O_SHADOW_VALUE))
        else $error("snapshot taken with trigger bit clear");

    // ****************************
    // checks: secure control
    // ****************************
    part_ns_zero_a: assert property (O_MSG_NONSECURE |-> !O_MSG_PARTITION_NS)
        else $error("partition ns set on nonsecure messages");
    scr_part_a: assert property (sec_req & ~I_REQ.write & sel_scr & (msg_ns_q | ns_allow_q)
        |=> !O_RDATA[SCR_PART_NS_BIT])
        else $error("partition ns bit not reserved zero");
    msg_sec_a: assert property (scr_wr & MSG_IMPL & !I_REQ.wdata[SCR_MSG_NS_BIT]
        & !I_REQ.wdata[SCR_NS_ALLOW_BIT] |=> !O_MSG_NONSECURE)
        else $error("messages not secure after write");
    msg_ns_a: assert property (scr_wr & I_REQ.wdata[SCR_MSG_NS_BIT] |=> O_MSG_NONSECURE)
        else $error("messages not nonsecure after write");
    ns_allow_write_a: assert property (scr_wr |=> ns_allow_q == $past(I_REQ.wdata[SCR_NS_ALLOW_BIT]))
        else $error("nonsecure access bit not written");
    sec_obs_write_a: assert property (scr_wr |=> O_SECURE_OBSERVE == $past(I_REQ.wdata[SCR_SEC_OBS_BIT]))
        else $error("secure observe not written");
    scr_rsvd_a: assert property (sec_req & ~I_REQ.write & sel_scr |=> O_RDATA[30:4] == 27'h0)
        else $error("secure control reserved bits nonzero");
    scr_absent_a: assert property (!SECURE_IMPL && I_REQ.valid && sel_scr |=> O_RDATA == 32'h0)
        else $error("absent secure control read nonzero");
    single_state_a: assert property (!SECURE_IMPL |-> O_MSG_NONSECURE)
        else $error("single state group message not nonsecure");

    // ****************************
    // checks: configuration
    // ****************************
    cfg_flags_a: assert property (access_ok & ~I_REQ.write & sel_cfgr
        |=> O_RDATA[25:20] == {PART_FILT_IMPL, PART_MON, SHARED_FILT, CAPTURE_IMPL, MSG_IMPL, RELOC_IMPL})
        else $error("configuration flags wrong");
    cfg_monitor_a: assert property (access_ok & ~I_REQ.write & sel_cfgr
        |=> !O_RDATA[CFG_PART_MON_BIT] || O_RDATA[CFG_MSG_BIT])
        else $error("partition monitoring without messages");
    cfg_rsvd_a: assert property (access_ok & ~I_REQ.write & sel_cfgr
        |=> O_RDATA[31:26] == 6'h0 && O_RDATA[19:14] == 6'h0 && O_RDATA[7:6] == 2'h0)
        else $error("configuration reserved bits nonzero");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the counter group register bank
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pcgc_pkg::*;
    localparam int NC = 4;
    localparam int CW = 32;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pcgc_req_s req = '0;
    logic [NC-1:0][CW-1:0] cnt = '0;
    logic [NC-1:0][CW-1:0] shadow;
    logic [NC-1:0][CW-1:0] snap;
    logic [NC-1:0][CW-1:0] keep;
    logic ack;
    logic [31:0] rdata;
    logic gen;
    logic sobs;
    logic msg_ns;
    logic part_ns;
    logic [31:0] rd;
    logic [31:0] wd;
    int bad_count = 0;
    int checks = 0;
    int seed = 32'h11d8;

    pcgc_regs #(.NUM_CTR(NC), .CTR_WIDTH(CW)) pcgc_regs_i (
        .I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_EVENT_COUNT(cnt), .O_ACK(ack), .O_RDATA(rdata),
        .O_SHADOW_VALUE(shadow), .O_GLOBAL_EN(gen), .O_SECURE_OBSERVE(sobs), .O_MSG_NONSECURE(msg_ns),
        .O_MSG_PARTITION_NS(part_ns)
    );

    always #10 clk = ~clk;

    // ****************************
    // helpers
    // ****************************
    function automatic logic [31:0] cfg_exp();
        return {6'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 6'h0, 6'(CW - 1), 2'h0, 6'(NC - 1)};
    endfunction

    function automatic logic [31:0] scr_exp(input logic [31:0] d);
        return {1'b1, 27'h0, d[3] & ~(d[2] | d[1]), d[2], d[1], d[0]};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic ns, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{valid: 1'b1, write: w, nonsecure: ns, addr: a, wdata: d};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk("ack", 32'h1, 32'(ack));
        rd = rdata;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        summarize();
    end

    // ****************************
    // tests
    // ****************************
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("global_en", 32'h0, 32'(gen));
        chk("msg_ns", 32'h1, 32'(msg_ns));
        chk("part_ns", 32'h0, 32'(part_ns));
        chk("sec_obs", 32'h0, 32'(sobs));
        acc(1'b0, 1'b0, CFGR_OFF, 32'h0);
        chk("cfg", cfg_exp(), rd);
        acc(1'b0, 1'b0, SCR_OFF, 32'h0);
        chk("scr_reset", 32'h8000_0006, rd);
        acc(1'b1, 1'b1, SCR_OFF, 32'h0);
        acc(1'b0, 1'b1, SCR_OFF, 32'h0);
        chk("scr_ns_read", 32'h0, rd);
        acc(1'b0, 1'b0, SCR_OFF, 32'h0);
        chk("scr_ns_write", 32'h8000_0006, rd);
        $display("test reset_and_id done");
        for (int i = 0; i < 24; i++) begin
            wd = (i == 0) ? 32'h8 : (i == 1) ? 32'hffff_fff0 : $random(seed);
            acc(1'b1, 1'b0, SCR_OFF, wd);
            chk("sec_obs", 32'(wd[0]), 32'(sobs));
            chk("msg_ns", 32'(wd[1] | wd[2]), 32'(msg_ns));
            chk("part_ns", 32'(wd[3] & ~(wd[1] | wd[2])), 32'(part_ns));
            acc(1'b0, 1'b0, SCR_OFF, 32'h0);
            chk("scr", scr_exp(wd), rd);
        end
        $display("test secure_control done");
        acc(1'b1, 1'b0, SCR_OFF, 32'h1);
        acc(1'b1, 1'b1, CR_OFF, 32'h1);
        chk("global_en", 32'h0, 32'(gen));
        acc(1'b0, 1'b1, CFGR_OFF, 32'h0);
        chk("cfg_denied", 32'h0, rd);
        acc(1'b1, 1'b0, SCR_OFF, 32'h2);
        acc(1'b1, 1'b1, CR_OFF, 32'h1);
        chk("global_en", 32'h1, 32'(gen));
        acc(1'b0, 1'b1, CR_OFF, 32'h0);
        chk("cr", 32'h1, rd);
        acc(1'b1, 1'b0, CR_OFF, 32'hffff_fffe);
        chk("global_en", 32'h0, 32'(gen));
        acc(1'b1, 1'b0, SCR_OFF, 32'h6);
        acc(1'b1, 1'b0, SCR_OFF, 32'h4);
        chk("msg_ns_step1", 32'h1, 32'(msg_ns));
        acc(1'b1, 1'b1, CR_OFF, 32'h1);
        chk("global_en_locked", 32'h0, 32'(gen));
        acc(1'b1, 1'b0, SCR_OFF, 32'h0);
        chk("msg_ns_step3", 32'h0, 32'(msg_ns));
        $display("test access_control done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            foreach (snap[k]) snap[k] = (i == 0) ? '1 : $random(seed);
            cnt <= snap;
            acc(1'b1, 1'b0, SNAP_OFF, (i == 1) ? 32'h1 : 32'hffff_ffff);
            foreach (snap[k]) chk("shadow", snap[k], shadow[k]);
            acc(1'b0, 1'b0, SNAP_OFF, 32'h0);
            chk("snap_read", 32'h0, rd);
        end
        keep = snap;
        @(posedge clk);
        cnt <= ~snap;
        acc(1'b1, 1'b0, SNAP_OFF, 32'hffff_fffe);
        foreach (keep[k]) chk("shadow_bit0", keep[k], shadow[k]);
        acc(1'b1, 1'b0, SCR_OFF, 32'h0);
        acc(1'b1, 1'b1, SNAP_OFF, 32'h1);
        foreach (keep[k]) chk("shadow_ns", keep[k], shadow[k]);
        acc(1'b0, 1'b0, 17'h00e80, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test snapshot done");
        summarize();
    end
endmodule
`default_nettype wire
